// File: core/smb_slave.sv
// slave end of the two-wire management bus with time-outs and stretching
// How it works
// - bus clock stays above 10 kHz mid-transfer
// - no clock edge for one slow period idles
// - bus clock never faster than 100 kHz
// - clock low 35 ms is a time-out
// - slave stretch total per message stays bounded
// - master extension per byte stays bounded
// - own address always acknowledged, even busy
// - any received command or data byte may be nacked
// - busy or invalid data answered by nack
// - only defined transaction formats on the bus
// - reserved host and alert addresses never claimed
`timescale 1ns/1ps
module smb_slave
  import smb_pkg::*;
#(
  parameter logic [6:0]  OWN_ADDR = SMB_DEFAULT_ADDR,
  parameter int unsigned TOUT_CYC = SMB_TOUT_CYC,
  parameter int unsigned SEXT_CYC = SMB_SEXT_CYC
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // bus wires
  smb_if.slave            bus,
  // received bytes
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_is_cmd,
  input  wire logic       rx_refuse,
  // bytes to send
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_taken,
  // status
  output logic            busy,
  output logic            timeout
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SS_IDLE    = 3'h0,
    SS_ADDR    = 3'h1,
    SS_WRITE   = 3'h2,
    SS_READ    = 3'h3,
    SS_STRETCH = 3'h4
  } smb_sstate_t;

  smb_sstate_t state_ff;
  logic [1:0]  scl_sync_ff;
  logic [1:0]  sda_sync_ff;
  logic        scl_d_ff;
  logic        sda_d_ff;
  logic [3:0]  bitcnt_ff;
  logic [7:0]  shreg_ff;
  logic [7:0]  txsh_ff;
  logic        rw_ff;
  logic        first_ff;
  logic        scl_oe_ff;
  logic        sda_oe_ff;
  logic [7:0]  rx_data_ff;
  logic        rx_valid_ff;
  logic        rx_is_cmd_ff;
  logic        tx_taken_ff;
  logic        busy_ff;
  logic        timeout_ff;
  smb_cnt_t    low_cnt_ff;
  smb_cnt_t    gap_cnt_ff;
  smb_cnt_t    sext_cnt_ff;
  logic        scl_s;
  logic        sda_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        tout_hit;
  logic        gap_hit;
  logic        sext_out;
  logic        addr_hit;
  logic [7:0]  nxt_tx;

  // ----------------------------------------------------------------
  // pin synchronisers and bus conditions
  // ----------------------------------------------------------------
  // two synchroniser flops plus a delay flop per wire, released lines idle high
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_d_ff    <= 1'b1;
      sda_d_ff    <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], bus.scl};
      sda_sync_ff <= {sda_sync_ff[0], bus.sda};
      scl_d_ff    <= scl_sync_ff[1];
      sda_d_ff    <= sda_sync_ff[1];
    end
  end

  // edges, start and stop from the second stage only
  assign scl_s    = scl_sync_ff[1];
  assign sda_s    = sda_sync_ff[1];
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_c  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_c   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // reserved addresses are never claimed even if configured
  assign addr_hit = (shreg_ff[7:1] == OWN_ADDR) && (OWN_ADDR != SMB_HOST_ADDR) &&
                    (OWN_ADDR != SMB_ALERT_ADDR);
  assign nxt_tx   = tx_valid ? tx_data : SMB_FILL_BYTE;

  // ----------------------------------------------------------------
  // time-out counters
  // ----------------------------------------------------------------
  // continuous clock low, stops one past the limit so the hit fires once
  always_ff @(posedge ref_clk) begin
    if (!reset_n || scl_s) begin
      low_cnt_ff <= '0;
    end else if (low_cnt_ff != smb_cnt_t'(TOUT_CYC)) begin
      low_cnt_ff <= low_cnt_ff + smb_cnt_t'(1);
    end
  end
  assign tout_hit = low_cnt_ff == smb_cnt_t'(TOUT_CYC - 1);

  // gap since last clock edge while a transfer is open
  always_ff @(posedge ref_clk) begin
    if (!reset_n || scl_rise || scl_fall || state_ff == SS_IDLE || state_ff == SS_STRETCH) begin
      gap_cnt_ff <= '0;
    end else if (gap_cnt_ff != smb_cnt_t'(SMB_IDLE_CYC)) begin
      gap_cnt_ff <= gap_cnt_ff + smb_cnt_t'(1);
    end
  end
  // a master slower than the minimum rate counts as gone
  assign gap_hit = gap_cnt_ff == smb_cnt_t'(SMB_IDLE_CYC - 1);

  // stretch time summed over one message, cleared when idle
  always_ff @(posedge ref_clk) begin
    if (!reset_n || state_ff == SS_IDLE) begin
      sext_cnt_ff <= '0;
    end else if (state_ff == SS_STRETCH && !sext_out) begin
      sext_cnt_ff <= sext_cnt_ff + smb_cnt_t'(1);
    end
  end
  assign sext_out = sext_cnt_ff == smb_cnt_t'(SEXT_CYC - 1);

  // ----------------------------------------------------------------
  // protocol state machine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_ff     <= SS_IDLE;
      bitcnt_ff    <= '0;
      shreg_ff     <= '0;
      txsh_ff      <= '0;
      rw_ff        <= 1'b0;
      first_ff     <= 1'b0;
      scl_oe_ff    <= 1'b0;
      sda_oe_ff    <= 1'b0;
      rx_data_ff   <= '0;
      rx_valid_ff  <= 1'b0;
      rx_is_cmd_ff <= 1'b0;
      tx_taken_ff  <= 1'b0;
      timeout_ff   <= 1'b0;
    end else begin
      rx_valid_ff <= 1'b0;
      tx_taken_ff <= 1'b0;
      timeout_ff  <= 1'b0;
      if (tout_hit || gap_hit) begin
        // abandon the transfer and free both wires
        state_ff   <= SS_IDLE;
        scl_oe_ff  <= 1'b0;
        sda_oe_ff  <= 1'b0;
        timeout_ff <= tout_hit;
      end else if (start_c) begin
        state_ff  <= SS_ADDR;
        bitcnt_ff <= '0;
        scl_oe_ff <= 1'b0;
        sda_oe_ff <= 1'b0;
      end else if (stop_c) begin
        state_ff  <= SS_IDLE;
        sda_oe_ff <= 1'b0;
      end else begin
        if (scl_rise) begin
          shreg_ff  <= {shreg_ff[6:0], sda_s};
          bitcnt_ff <= bitcnt_ff + 4'h1;
        end
        unique case (state_ff)
          SS_IDLE: begin
            sda_oe_ff <= 1'b0;
          end
          SS_ADDR: begin
            if (scl_fall && bitcnt_ff == SMB_BYTE_BITS) begin
              // own address acked whatever the user side is doing
              if (addr_hit) begin
                sda_oe_ff <= 1'b1;
                rw_ff     <= shreg_ff[0];
              end else begin
                state_ff <= SS_IDLE;
              end
            end else if (scl_fall && bitcnt_ff == SMB_ACK_BIT) begin
              sda_oe_ff <= 1'b0;
              bitcnt_ff <= '0;
              first_ff  <= 1'b1;
              if (rw_ff) begin
                state_ff  <= SS_STRETCH;
                scl_oe_ff <= 1'b1;
              end else begin
                state_ff <= SS_WRITE;
              end
            end
          end
          SS_WRITE: begin
            if (scl_fall && bitcnt_ff == SMB_BYTE_BITS) begin
              rx_data_ff   <= shreg_ff;
              rx_valid_ff  <= 1'b1;
              rx_is_cmd_ff <= first_ff;
              first_ff     <= 1'b0;
              // any byte, the last included, can be refused
              sda_oe_ff    <= ~rx_refuse;
            end else if (scl_fall && bitcnt_ff == SMB_ACK_BIT) begin
              sda_oe_ff <= 1'b0;
              bitcnt_ff <= '0;
            end
          end
          SS_STRETCH: begin
            // hold the clock low until data is ready or the budget ends
            // first bit is set up here, the clock is freed one cycle later
            if (tx_valid || sext_out) begin
              txsh_ff     <= nxt_tx;
              sda_oe_ff   <= ~nxt_tx[7];
              tx_taken_ff <= tx_valid;
              state_ff    <= SS_READ;
            end
          end
          SS_READ: begin
            scl_oe_ff <= 1'b0;                                            // end of stretch
            if (scl_fall && bitcnt_ff < SMB_BYTE_BITS) begin
              txsh_ff   <= {txsh_ff[6:0], 1'b0};
              sda_oe_ff <= ~txsh_ff[6];
            end else if (scl_fall && bitcnt_ff == SMB_BYTE_BITS) begin
              sda_oe_ff <= 1'b0;                                          // master acks
            end else if (scl_fall && bitcnt_ff == SMB_ACK_BIT) begin
              bitcnt_ff <= '0;
              if (!shreg_ff[0]) begin
                state_ff  <= SS_STRETCH;
                scl_oe_ff <= 1'b1;
              end else begin
                state_ff <= SS_IDLE;                                      // nack ends reading
              end
            end
          end
          default: begin
            state_ff <= SS_IDLE;
          end
        endcase
      end
    end
  end

  // busy flag follows the state one cycle late
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= state_ff != SS_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.s_scl_o  = 1'b0;
  assign bus.s_sda_o  = 1'b0;
  assign bus.s_scl_oe = scl_oe_ff;
  assign bus.s_sda_oe = sda_oe_ff;
  assign rx_data      = rx_data_ff;
  assign rx_valid     = rx_valid_ff;
  assign rx_is_cmd    = rx_is_cmd_ff;
  assign tx_taken     = tx_taken_ff;
  assign busy         = busy_ff;
  assign timeout      = timeout_ff;

endmodule

// File: include/smb_pkg.sv
// shared constants and types for both ends of the two-wire management bus
package smb_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned SMB_CLK_NS     = 40;      // ref_clk period
  localparam int unsigned SMB_FMAX_KHZ   = 100;     // fastest bus clock
  localparam int unsigned SMB_FMIN_KHZ   = 10;      // slowest bus clock
  localparam int unsigned SMB_TOUT_MS    = 35;      // clock low time-out
  localparam int unsigned SMB_SCL_MIN_NS = 1000000 / SMB_FMAX_KHZ;
  // quarter bit, rounded up so the bit never beats the fastest clock
  localparam int unsigned SMB_QTR_CYC    = (SMB_SCL_MIN_NS + 4 * SMB_CLK_NS - 1) / (4 * SMB_CLK_NS);
  localparam int unsigned SMB_IDLE_NS    = 1000000 / SMB_FMIN_KHZ;
  // longest gap between clock edges, rounded down
  localparam int unsigned SMB_IDLE_CYC   = SMB_IDLE_NS / SMB_CLK_NS;
  localparam int unsigned SMB_TOUT_CYC   = SMB_TOUT_MS * 1000000 / SMB_CLK_NS;
  localparam int unsigned SMB_SEXT_CYC   = 500000;  // slave stretch budget per message
  typedef logic [23:0] smb_cnt_t;
  typedef logic [6:0]  smb_qtr_t;

  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  localparam logic [3:0] SMB_BYTE_BITS = 4'h8;     // data bits of a byte
  localparam logic [3:0] SMB_ACK_BIT   = 4'h9;     // count after the ack slot
  localparam logic [7:0] SMB_FILL_BYTE = 8'hFF;    // sent when no data ready
  localparam logic [1:0] SMB_PH_HIGH   = 2'h2;     // quarter that needs clock high
  localparam logic [1:0] SMB_PH_LAST   = 2'h3;

  // ----------------------------------------------------------------
  // reserved addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] SMB_HOST_ADDR    = 7'h08;
  localparam logic [6:0] SMB_ALERT_ADDR   = 7'h0C;
  localparam logic [6:0] SMB_DEFAULT_ADDR = 7'h61;

endpackage

// File: include/smb_if.sv
// open-drain clock and data wires joining the host end and the slave end
`timescale 1ns/1ps
interface smb_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_scl_o;
  logic s_scl_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // wired-and: any enabled low driver pulls the wire low, else pull-up
  assign scl = ~((m_scl_oe & ~m_scl_o) | (s_scl_oe & ~s_scl_o));
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport slave  (output s_scl_o, s_scl_oe, s_sda_o, s_sda_oe, input scl, sda);
endinterface

// File: core/smb_master.sv
// host end of the two-wire management bus: write byte and read byte
`timescale 1ns/1ps
module smb_master
  import smb_pkg::*;
#(
  parameter int unsigned TOUT_CYC = SMB_TOUT_CYC
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // bus wires
  smb_if.master           bus,
  // request
  input  wire logic       req,
  input  wire logic       req_read,
  input  wire logic [6:0] req_addr,
  input  wire logic [7:0] req_cmd,
  input  wire logic [7:0] req_data,
  // answer
  output logic            busy,
  output logic            done,
  output logic            nacked,
  output logic [7:0]      rd_data,
  output logic            timeout
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MO_START = 2'h0,
    MO_TX    = 2'h1,
    MO_RX    = 2'h2,
    MO_STOP  = 2'h3
  } smb_op_t;

  logic       run_ff;
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  smb_qtr_t   qcnt_ff;
  logic [1:0] ph_ff;
  logic [2:0] step_ff;
  logic [3:0] bit_ff;
  logic [7:0] txsh_ff;
  logic [7:0] rxsh_ff;
  logic       ackbit_ff;
  logic       rd_ff;
  logic [6:0] addr_ff;
  logic [7:0] cmd_ff;
  logic [7:0] data_ff;
  logic       scl_oe_ff;
  logic       sda_oe_ff;
  logic       done_ff;
  logic       nacked_ff;
  logic [7:0] rd_data_ff;
  logic       timeout_ff;
  smb_cnt_t   low_cnt_ff;
  logic       scl_s;
  logic       sda_s;
  logic       tick;
  logic       adv;
  logic       tout_hit;
  smb_op_t    op;
  logic [7:0] op_byte;
  logic [2:0] stop_step;

  // ----------------------------------------------------------------
  // synchronisers, quarter-bit divider and clock-low time-out
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], bus.scl};
      sda_sync_ff <= {sda_sync_ff[0], bus.sda};
    end
  end
  assign scl_s = scl_sync_ff[1];
  assign sda_s = sda_sync_ff[1];

  // four quarters per bit, each rounded up: never above the fastest rate
  // high quarter counts only once the wire is seen high, so a stretch
  // never shortens the high time below a full quarter
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !run_ff || tick || (ph_ff == SMB_PH_HIGH && !scl_s)) begin
      qcnt_ff <= '0;
    end else begin
      qcnt_ff <= qcnt_ff + smb_qtr_t'(1);
    end
  end
  assign tick = qcnt_ff == smb_qtr_t'(SMB_QTR_CYC - 1);
  // a stretched clock holds the high quarter until the wire is high
  assign adv  = tick && !(ph_ff == SMB_PH_HIGH && !scl_s);

  always_ff @(posedge ref_clk) begin
    if (!reset_n || scl_s) begin
      low_cnt_ff <= '0;
    end else if (low_cnt_ff != smb_cnt_t'(TOUT_CYC)) begin
      low_cnt_ff <= low_cnt_ff + smb_cnt_t'(1);
    end
  end
  assign tout_hit = low_cnt_ff == smb_cnt_t'(TOUT_CYC - 1);

  // ----------------------------------------------------------------
  // transaction sequence
  // ----------------------------------------------------------------
  // write byte: S aw cmd data P ; read byte: S aw cmd Sr ar rx P
  always_comb begin
    op      = MO_TX;
    op_byte = {addr_ff, 1'b0};
    unique case (step_ff)
      3'h0: op = MO_START;
      3'h1: op_byte = {addr_ff, 1'b0};
      3'h2: op_byte = cmd_ff;
      3'h3: begin
        op      = rd_ff ? MO_START : MO_TX;
        op_byte = data_ff;
      end
      3'h4: begin
        op      = rd_ff ? MO_TX : MO_STOP;
        op_byte = {addr_ff, 1'b1};
      end
      3'h5: op = MO_RX;
      default: op = MO_STOP;
    endcase
  end
  assign stop_step = rd_ff ? 3'h6 : 3'h4;

  // ----------------------------------------------------------------
  // bit engine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      run_ff     <= 1'b0;
      ph_ff      <= '0;
      step_ff    <= '0;
      bit_ff     <= '0;
      txsh_ff    <= '0;
      rxsh_ff    <= '0;
      ackbit_ff  <= 1'b0;
      rd_ff      <= 1'b0;
      addr_ff    <= '0;
      cmd_ff     <= '0;
      data_ff    <= '0;
      scl_oe_ff  <= 1'b0;
      sda_oe_ff  <= 1'b0;
      done_ff    <= 1'b0;
      nacked_ff  <= 1'b0;
      rd_data_ff <= '0;
      timeout_ff <= 1'b0;
    end else begin
      done_ff    <= 1'b0;
      timeout_ff <= 1'b0;
      if (!run_ff) begin
        if (req && req_addr == SMB_HOST_ADDR) begin
          done_ff   <= 1'b1;
          nacked_ff <= 1'b1;
        end else if (req) begin
          run_ff    <= 1'b1;
          rd_ff     <= req_read;
          addr_ff   <= req_addr;
          cmd_ff    <= req_cmd;
          data_ff   <= req_data;
          step_ff   <= '0;
          ph_ff     <= '0;
          bit_ff    <= '0;
          nacked_ff <= 1'b0;
        end
      end else if (tout_hit) begin
        // drop the transfer and free both wires
        run_ff     <= 1'b0;
        scl_oe_ff  <= 1'b0;
        sda_oe_ff  <= 1'b0;
        timeout_ff <= 1'b1;
        done_ff    <= 1'b1;
      end else if (adv) begin
        ph_ff <= ph_ff + 2'h1;
        unique case (ph_ff)
          2'h0: begin
            // clock is low here: set up data or stop/start level
            unique case (op)
              MO_START: sda_oe_ff <= 1'b0;
              MO_STOP:  sda_oe_ff <= 1'b1;
              MO_TX:    sda_oe_ff <= (bit_ff < SMB_BYTE_BITS) & ~txsh_ff[7];
              MO_RX:    sda_oe_ff <= 1'b0;                                // nack the last byte
            endcase
            if (op == MO_TX && bit_ff == '0) begin
              txsh_ff   <= op_byte;
              sda_oe_ff <= ~op_byte[7];
            end
          end
          2'h1: scl_oe_ff <= 1'b0;
          2'h2: begin
            unique case (op)
              MO_START: sda_oe_ff <= 1'b1;
              MO_STOP:  sda_oe_ff <= 1'b0;
              MO_TX:    ackbit_ff <= sda_s;
              MO_RX:    if (bit_ff < SMB_BYTE_BITS) rxsh_ff <= {rxsh_ff[6:0], sda_s};
            endcase
          end
          default: begin
            // fixed last quarter, clock high until pulled low at its end: the host never extends the clock itself
            if (op == MO_STOP) begin
              run_ff     <= 1'b0;
              done_ff    <= 1'b1;
              rd_data_ff <= rxsh_ff;
            end else begin
              scl_oe_ff <= 1'b1;
              if (op == MO_START || bit_ff == SMB_BYTE_BITS) begin
                bit_ff <= '0;
                if (op == MO_TX && ackbit_ff) begin
                  nacked_ff <= 1'b1;
                  step_ff   <= stop_step;
                end else begin
                  step_ff <= step_ff + 3'h1;
                end
              end else begin
                bit_ff  <= bit_ff + 4'h1;
                txsh_ff <= {txsh_ff[6:0], 1'b0};
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.m_scl_o  = 1'b0;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_scl_oe = scl_oe_ff;
  assign bus.m_sda_oe = sda_oe_ff;
  assign busy         = run_ff;
  assign done         = done_ff;
  assign nacked       = nacked_ff;
  assign rd_data      = rd_data_ff;
  assign timeout      = timeout_ff;

endmodule

// File: testbench/smb_properties.sv
// link checks between the host end and the slave end
`timescale 1ns/1ps
module smb_properties
  import smb_pkg::*;
#(
  parameter logic [6:0]  OWN_ADDR = SMB_DEFAULT_ADDR,
  parameter int unsigned SEXT_CYC = SMB_SEXT_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // link
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_scl_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic        in_ff;
  logic        fst_ff;
  logic [3:0]  bit_ff;
  logic [7:0]  sh_ff;
  logic [11:0] gap_ff;
  logic [11:0] rise_ff;
  logic [23:0] ext_ff;
  // frame from start to stop
  always_ff @(posedge ref_clk) begin
    if (!reset_n) in_ff <= 1'b0;
    else if ($fell(sda) && scl) in_ff <= 1'b1;
    else if ($rose(sda) && scl) in_ff <= 1'b0;
  end
  // bit count and shifted byte
  always_ff @(posedge ref_clk) begin
    if (!reset_n || ($fell(sda) && scl)) begin
      bit_ff <= 4'h0;
      fst_ff <= 1'b1;
    end else if ($rose(scl) && bit_ff == SMB_BYTE_BITS) begin
      bit_ff <= 4'h0;
      fst_ff <= 1'b0;
    end else if ($rose(scl)) begin
      bit_ff <= bit_ff + 4'h1;
      sh_ff  <= {sh_ff[6:0], sda};
    end
  end
  // cycles since last clock edge and last rise
  always_ff @(posedge ref_clk) begin
    if (!reset_n || $changed(scl) || ($fell(sda) && scl)) gap_ff <= 12'h000;
    else if (gap_ff != 12'hFFF) gap_ff <= gap_ff + 12'h001;
    if (!reset_n) rise_ff <= 12'hFFF;
    else if ($rose(scl)) rise_ff <= 12'h000;
    else if (rise_ff != 12'hFFF) rise_ff <= rise_ff + 12'h001;
  end
  // slave stretch total in this frame
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !in_ff) ext_ff <= 24'h000000;
    else if (s_scl_oe) ext_ff <= ext_ff + 24'h000001;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_start; $fell(sda) && scl; endsequence
  sequence s_stop; $rose(sda) && scl; endsequence
  sequence s_addr_ack; $rose(scl) && in_ff && fst_ff && bit_ff == SMB_BYTE_BITS; endsequence
  property p_fmax; $rose(scl) |-> rise_ff >= 12'h0F9; endproperty
  property p_fmin; in_ff |-> gap_ff < 12'h9C4; endproperty
  property p_host_start; s_start |-> m_sda_oe; endproperty
  property p_sda_low_clk; $rose(s_sda_oe) |-> !scl; endproperty
  property p_ack_own; s_addr_ack ##0 (sh_ff[7:1] == OWN_ADDR) |-> !sda; endproperty
  property p_no_foreign; s_addr_ack ##0 (sh_ff[7:1] != OWN_ADDR) |-> !s_sda_oe; endproperty
  property p_ext; s_scl_oe |-> ext_ff <= SEXT_CYC + 4; endproperty
  property p_stretch_low; $rose(s_scl_oe) |-> !$past(scl); endproperty
  property p_stop_free; s_stop |=> (!m_scl_oe && !s_scl_oe && !s_sda_oe)[*8]; endproperty
  a_fmax: assert property (p_fmax) else $error("clock too fast");
  a_fmin: assert property (p_fmin) else $error("clock too slow in frame");
  a_host_start: assert property (p_host_start) else $error("start not by host");
  a_sda_low_clk: assert property (p_sda_low_clk) else $error("slave data moved in clock high");
  a_ack_own: assert property (p_ack_own) else $error("own address not acked");
  a_no_foreign: assert property (p_no_foreign) else $error("foreign address acked");
  a_ext: assert property (p_ext) else $error("stretch budget exceeded");
  a_stretch_low: assert property (p_stretch_low) else $error("stretch began on high clock");
  a_stop_free: assert property (p_stop_free) else $error("lines held after stop");
endmodule

// File: testbench/smbus_port_timing_ack_rules_bench.sv
// bench: host and slave ends joined, plus a host facing a stuck clock
`timescale 1ns/1ps
module smbus_port_timing_ack_rules_bench;
  import smb_pkg::*;
  localparam int unsigned TOUT = 3000;
  localparam int unsigned SEXT = 1000;
  logic       ref_clk, reset_n, req, req2, req_read, tx_valid, rx_refuse;
  logic [6:0] req_addr;
  logic [7:0] req_cmd, req_data, tx_data, m_rd, s_rx;
  logic       m_busy, m_done, m_nack, m_tout, s_rxv, s_cmd, s_taken, m2_done, m2_busy, m2_tout, s_busy, s_tout;
  logic [7:0] rx_log [4];
  logic       cmd_log [4];
  int         err_total, samples_checked, cyc, rx_cnt, tk_cnt, ref_idx;
  smb_if bus1 ();
  smb_if bus2 ();
  smb_master #(.TOUT_CYC(TOUT)) smb_master_i (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus1.master),
    .req(req), .req_read(req_read), .req_addr(req_addr), .req_cmd(req_cmd), .req_data(req_data),
    .busy(m_busy), .done(m_done), .nacked(m_nack), .rd_data(m_rd), .timeout(m_tout));
  smb_slave #(.TOUT_CYC(TOUT), .SEXT_CYC(SEXT)) smb_slave_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .bus(bus1.slave), .rx_data(s_rx), .rx_valid(s_rxv), .rx_is_cmd(s_cmd), .rx_refuse(rx_refuse),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_taken(s_taken), .busy(s_busy), .timeout(s_tout));
  smb_master #(.TOUT_CYC(TOUT)) smb_master_to_i (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus2.master),
    .req(req2), .req_read(req_read), .req_addr(req_addr), .req_cmd(req_cmd), .req_data(req_data),
    .busy(m2_busy), .done(m2_done), .nacked(), .rd_data(), .timeout(m2_tout));
  smb_properties #(.SEXT_CYC(SEXT)) smb_properties_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .m_scl_oe(bus1.m_scl_oe), .m_sda_oe(bus1.m_sda_oe), .s_scl_oe(bus1.s_scl_oe),
    .s_sda_oe(bus1.s_sda_oe), .scl(bus1.scl), .sda(bus1.sda));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // refuse the chosen byte, log received bytes
  assign rx_refuse = (rx_cnt == ref_idx);
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (s_rxv) begin
      rx_log[rx_cnt[1:0]]  <= s_rx;
      cmd_log[rx_cnt[1:0]] <= s_cmd;
      rx_cnt               <= rx_cnt + 1;
    end
    if (s_taken) tk_cnt <= tk_cnt + 1;
    if (cyc == 90000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_done(input bit two);
    int n;
    n = 0;
    while ((two ? m2_done : m_done) !== 1'b1 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 20000) cmp(8'h00, 8'h01);
  endtask
  // one host transaction, then its nack and read byte
  task automatic xfer(input logic r, input logic [6:0] a, input int ri, input logic nk, input logic [7:0] rdx);
    @(negedge ref_clk);
    rx_cnt   = 0;
    tk_cnt   = 0;
    ref_idx  = ri;
    req_read = r;
    req_addr = a;
    req      = 1'b1;
    @(negedge ref_clk);
    req = 1'b0;
    wait_done(1'b0);
    cmp({7'h00, m_nack}, {7'h00, nk});
    if (r) cmp(m_rd, rdx);
    $display("test addr %h read %0d ended", a, r);
  endtask
  task automatic report_and_stop;
    $display("counts: %0d checked, %0d bad", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    {req, req2, req_read, tx_valid, err_total, samples_checked, cyc, rx_cnt, tk_cnt} = '0;
    {bus2.s_scl_o, bus2.s_sda_o, bus2.s_scl_oe, bus2.s_sda_oe} = 4'h0;
    {req_addr, req_cmd, req_data, tx_data} = {SMB_DEFAULT_ADDR, 8'hA5, 8'h3C, 8'h5A};
    ref_idx = 9;
    reset_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    reset_n = 1'b1;
    xfer(1'b0, SMB_DEFAULT_ADDR, 9, 1'b0, 8'h00);
    cmp(rx_log[0], 8'hA5);
    cmp(rx_log[1], 8'h3C);
    cmp({6'h00, cmd_log[0], cmd_log[1]}, 8'h02);
    cmp({6'h00, s_busy, s_tout}, 8'h00);
    for (int i = 0; i < 2; i++) begin
      xfer(1'b0, SMB_DEFAULT_ADDR, i, 1'b1, 8'h00);
      cmp(8'(rx_cnt), 8'(i + 1));
    end
    xfer(1'b0, 7'h22, 9, 1'b1, 8'h00);
    xfer(1'b0, SMB_HOST_ADDR, 9, 1'b1, 8'h00);
    cmp(8'(rx_cnt), 8'h00);
    tx_valid = 1'b1;
    xfer(1'b1, SMB_DEFAULT_ADDR, 9, 1'b0, 8'h5A);
    cmp(8'(tk_cnt), 8'h01);
    tx_valid = 1'b0;
    xfer(1'b1, SMB_DEFAULT_ADDR, 9, 1'b0, SMB_FILL_BYTE);
    // stuck clock on the second link
    req2 = 1'b1;
    @(negedge ref_clk);
    req2 = 1'b0;
    repeat (600) @(negedge ref_clk);
    bus2.s_scl_oe = 1'b1;
    wait_done(1'b1);
    cmp({7'h00, m2_tout}, 8'h01);
    @(negedge ref_clk);
    cmp({5'h00, m2_busy, bus2.m_scl_oe, bus2.m_sda_oe}, 8'h00);
    bus2.s_scl_oe = 1'b0;
    $display("test stuck clock ended");
    report_and_stop();
  end
endmodule
